// >>> inc/sbs_regs.svh
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

`define SBS_MATCH1_A 8'h86
`define SBS_MATCH1_B 8'h30
`define SBS_MATCH2_A 8'h79
`define SBS_MATCH2_B 8'hcf

`define SBS_CMD_ROMEMU 8'hd0
`define SBS_CMD_SECURE 8'hfa
`define SBS_CMD_ERASE 8'hf0
`define SBS_CMD_WRITE 8'h30
`define SBS_CMD_READ 8'h40
`define SBS_CMD_RAMLOAD 8'h60
`define SBS_CMD_PRODID 8'hc0
`define SBS_CMD_STATUS 8'hc3

`define SBS_ROMEMU_OK 8'hd1
`define SBS_SECURE_OK 8'hfb
`define SBS_ERR_CMD 8'h63
`define SBS_ERR_FRAME 8'ha1
`define SBS_ERR_OVERRUN 8'ha3

`define SBS_ERR_REPEAT 2'h3
`define SBS_ONE_REPEAT 2'h1
`define SBS_ADDR_BYTES 3'h6

`endif

// >>> inc/sbs_pkg.sv
package sbs_pkg;

   typedef enum logic [3:0] {
      SBS_MATCH1 = 4'h0,
      SBS_MATCH2 = 4'h1,
      SBS_CMD = 4'h2,
      SBS_ROMSET = 4'h3,
      SBS_ADDR = 4'h4,
      SBS_CNTRD = 4'h5,
      SBS_PWCMP = 4'h6,
      SBS_ERRTX = 4'h7,
      SBS_EXT = 4'h8,
      SBS_IDLE = 4'h9
   } sbs_state_type;

endpackage

// >>> core/sbs_tx_repeat.sv
`include "sbs_regs.svh"

// Holds one reply byte and sends it a given number of times.
module sbs_tx_repeat
   import sbs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [7:0] loadData,
   input wire logic [1:0] loadRepeat,
   input wire logic txReady,
   output logic txValid,
   output logic [7:0] txData
);

   logic [1:0] repeatLeft;
   logic [1:0] next_repeatLeft;
   logic next_txValid;
   logic [7:0] next_txData;

   always_comb begin
      next_repeatLeft = repeatLeft;
      next_txValid = txValid;
      next_txData = txData;
      if (txValid && txReady) begin
         next_repeatLeft = repeatLeft - 2'h1;
         if (repeatLeft == `SBS_ONE_REPEAT) begin
            next_txValid = 1'b0;
         end
      end else if (load && !txValid) begin
         next_repeatLeft = loadRepeat;
         next_txValid = 1'b1;
         next_txData = loadData;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         repeatLeft <= 2'h0;
         txValid <= 1'b0;
         txData <= 8'h00;
      end else begin
         repeatLeft <= next_repeatLeft;
         txValid <= next_txValid;
         txData <= next_txData;
      end
   end

endmodule

// >>> core/sbs_cmd_handler.sv
`include "sbs_regs.svh"

module sbs_cmd_handler
   import sbs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxFrameErr,
   input wire logic rxOverrun,
   input wire logic txReady,
   output logic txValid,
   output logic [7:0] txData,
   output logic memReq,
   output logic [23:0] memAddr,
   input wire logic memAck,
   input wire logic [7:0] memData,
   input wire logic partBlank,
   input wire logic securityStored,
   input wire logic chipEraseDone,
   input wire logic extDone,
   output logic extStart,
   output logic [7:0] extCmd,
   output logic idle,
   output logic security_program_enabled_flag,
   output logic parallelReadAllowed,
   output logic sectorEraseAllowed
);

   sbs_state_type state, next_state;
   logic [2:0] addrIdx, next_addrIdx;
   logic [23:0] countAddr, next_countAddr;
   logic [23:0] startAddr, next_startAddr;
   logic [7:0] pwCount, next_pwCount;
   logic [7:0] pwIdx, next_pwIdx;
   logic [7:0] pwRx, next_pwRx;
   logic [7:0] pwFlash, next_pwFlash;
   logic gotRx, next_gotRx;
   logic gotFlash, next_gotFlash;
   logic next_memReq;
   logic [23:0] next_memAddr;
   logic next_extStart;
   logic [7:0] next_extCmd;
   logic next_flag;
   logic txLoad;
   logic [7:0] txLoadData;
   logic [1:0] txLoadRep;
   logic rxErr;
   logic [7:0] cmpRx, cmpFlash;
   logic cmpReady;

   assign rxErr = rxFrameErr || rxOverrun;
   assign cmpRx = gotRx ? pwRx : rxData;
   assign cmpFlash = gotFlash ? pwFlash : memData;
   assign cmpReady = (gotRx || rxValid) && (gotFlash || (memReq && memAck));

   sbs_tx_repeat u_tx (
      .clock(clock),
      .rst_n(rst_n),
      .load(txLoad),
      .loadData(txLoadData),
      .loadRepeat(txLoadRep),
      .txReady(txReady),
      .txValid(txValid),
      .txData(txData)
   );

   always_comb begin
      next_state = state;
      next_addrIdx = addrIdx;
      next_countAddr = countAddr;
      next_startAddr = startAddr;
      next_pwCount = pwCount;
      next_pwIdx = pwIdx;
      next_pwRx = pwRx;
      next_pwFlash = pwFlash;
      next_gotRx = gotRx;
      next_gotFlash = gotFlash;
      next_memReq = memReq;
      next_memAddr = memAddr;
      next_extStart = 1'b0;
      next_extCmd = extCmd;
      next_flag = security_program_enabled_flag | securityStored;
      txLoad = 1'b0;
      txLoadData = rxData;
      txLoadRep = `SBS_ONE_REPEAT;
      if (chipEraseDone) begin
         next_flag = 1'b0;
      end
      case (state)
         SBS_MATCH1: begin
            if (rxValid && !rxErr && (rxData == `SBS_MATCH1_A ||
                rxData == `SBS_MATCH1_B)) begin
               txLoad = 1'b1;
               next_state = SBS_MATCH2;
            end
         end
         SBS_MATCH2: begin
            if (rxValid && !rxErr && (rxData == `SBS_MATCH2_A ||
                rxData == `SBS_MATCH2_B)) begin
               txLoad = 1'b1;
               next_state = SBS_CMD;
            end
         end
         SBS_CMD: begin
            if (rxValid) begin
               txLoad = 1'b1;
               next_state = SBS_ERRTX;
               txLoadRep = `SBS_ERR_REPEAT;
               if (rxFrameErr) begin
                  txLoadData = `SBS_ERR_FRAME;
               end else if (rxOverrun) begin
                  txLoadData = `SBS_ERR_OVERRUN;
               end else begin
                  txLoadData = `SBS_ERR_CMD;
                  case (rxData)
                     `SBS_CMD_ROMEMU: begin
                        txLoadData = rxData;
                        txLoadRep = `SBS_ONE_REPEAT;
                        next_state = SBS_ROMSET;
                     end
                     `SBS_CMD_SECURE: begin
                        txLoadData = rxData;
                        txLoadRep = `SBS_ONE_REPEAT;
                        next_addrIdx = 3'h0;
                        next_state = SBS_ADDR;
                     end
                     `SBS_CMD_WRITE, `SBS_CMD_RAMLOAD: begin
                        // Refused with the command error code while security_program_enabled_flag is set
                        if (!security_program_enabled_flag) begin
                           txLoadData = rxData;
                           txLoadRep = `SBS_ONE_REPEAT;
                           next_extStart = 1'b1;
                           next_extCmd = rxData;
                           next_state = SBS_EXT;
                        end
                     end
                     `SBS_CMD_ERASE, `SBS_CMD_READ, `SBS_CMD_PRODID,
                     `SBS_CMD_STATUS: begin
                        txLoadData = rxData;
                        txLoadRep = `SBS_ONE_REPEAT;
                        next_extStart = 1'b1;
                        next_extCmd = rxData;
                        next_state = SBS_EXT;
                     end
                     default: begin
                        txLoadData = `SBS_ERR_CMD;
                     end
                  endcase
               end
            end
         end
         SBS_ROMSET: begin
            // Set value is discarded; the setting has no effect here
            if (rxValid) begin
               if (rxErr) begin
                  next_state = SBS_IDLE;
               end else begin
                  txLoad = 1'b1;
                  txLoadData = `SBS_ROMEMU_OK;
                  next_state = SBS_CMD;
               end
            end
         end
         SBS_ADDR: begin
            if (rxValid) begin
               if (rxErr) begin
                  next_state = SBS_IDLE;
               end else begin
                  // No reply for address bytes
                  if (addrIdx < 3'h3) begin
                     next_countAddr = {countAddr[15:0], rxData};
                  end else begin
                     next_startAddr = {startAddr[15:0], rxData};
                  end
                  next_addrIdx = addrIdx + 3'h1;
                  if (addrIdx == `SBS_ADDR_BYTES - 3'h1) begin
                     if (partBlank) begin
                        next_state = SBS_IDLE;
                     end else begin
                        next_memReq = 1'b1;
                        next_memAddr = next_countAddr;
                        next_state = SBS_CNTRD;
                     end
                  end
               end
            end
         end
         SBS_CNTRD: begin
            if (rxValid && rxErr) begin
               next_state = SBS_IDLE;
            end else if (memAck) begin
               next_pwCount = memData;
               next_pwIdx = 8'h00;
               next_gotRx = 1'b0;
               next_gotFlash = 1'b0;
               if (memData == 8'h00) begin
                  next_memReq = 1'b0;
                  next_flag = 1'b1;
                  txLoad = 1'b1;
                  txLoadData = `SBS_SECURE_OK;
                  next_state = SBS_CMD;
               end else begin
                  next_memAddr = startAddr;
                  next_state = SBS_PWCMP;
               end
            end
         end
         SBS_PWCMP: begin
            if (rxValid && !gotRx) begin
               next_pwRx = rxData;
               next_gotRx = 1'b1;
            end
            if (memReq && memAck) begin
               next_pwFlash = memData;
               next_gotFlash = 1'b1;
               next_memReq = 1'b0;
            end
            if (rxValid && rxErr) begin
               next_memReq = 1'b0;
               next_state = SBS_IDLE;
            end else if (cmpReady) begin
               next_gotRx = 1'b0;
               next_gotFlash = 1'b0;
               if (cmpRx != cmpFlash) begin
                  next_memReq = 1'b0;
                  next_state = SBS_IDLE;
               end else if (pwIdx + 8'h01 == pwCount) begin
                  next_memReq = 1'b0;
                  next_flag = 1'b1;
                  txLoad = 1'b1;
                  txLoadData = `SBS_SECURE_OK;
                  next_state = SBS_CMD;
               end else begin
                  next_pwIdx = pwIdx + 8'h01;
                  next_memReq = 1'b1;
                  next_memAddr = memAddr + 24'h1;
               end
            end
         end
         SBS_ERRTX: begin
            if (!txValid) begin
               next_state = SBS_IDLE;
            end
         end
         SBS_EXT: begin
            if (extDone) begin
               next_state = SBS_CMD;
            end
         end
         SBS_IDLE: begin
            // Only the reset pin leaves this state
            next_state = SBS_IDLE;
         end
         default: begin
            next_state = SBS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= SBS_MATCH1;
         addrIdx <= 3'h0;
         countAddr <= 24'h0;
         startAddr <= 24'h0;
         pwCount <= 8'h00;
         pwIdx <= 8'h00;
         pwRx <= 8'h00;
         pwFlash <= 8'h00;
         gotRx <= 1'b0;
         gotFlash <= 1'b0;
         memReq <= 1'b0;
         memAddr <= 24'h0;
         extStart <= 1'b0;
         extCmd <= 8'h00;
         idle <= 1'b0;
         security_program_enabled_flag <= 1'b0;
         parallelReadAllowed <= 1'b0;
         sectorEraseAllowed <= 1'b0;
      end else begin
         state <= next_state;
         addrIdx <= next_addrIdx;
         countAddr <= next_countAddr;
         startAddr <= next_startAddr;
         pwCount <= next_pwCount;
         pwIdx <= next_pwIdx;
         pwRx <= next_pwRx;
         pwFlash <= next_pwFlash;
         gotRx <= next_gotRx;
         gotFlash <= next_gotFlash;
         memReq <= next_memReq;
         memAddr <= next_memAddr;
         extStart <= next_extStart;
         extCmd <= next_extCmd;
         idle <= next_state == SBS_IDLE;
         security_program_enabled_flag <= next_flag;
         parallelReadAllowed <= !next_flag;
         sectorEraseAllowed <= !next_flag;
      end
   end

   property p_match1_echo;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_MATCH1 && rxValid && !rxErr && !txValid &&
      (rxData == `SBS_MATCH1_A || rxData == `SBS_MATCH1_B)
      |=> txValid && txData == $past(rxData);
   endproperty
   a_match1_echo: assert property (p_match1_echo)
      else $error("first matching byte not echoed");

   property p_match2_bad;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_MATCH2 && rxValid && !txValid &&
      rxData != `SBS_MATCH2_A && rxData != `SBS_MATCH2_B
      |=> !txValid && state == SBS_MATCH2;
   endproperty
   a_match2_bad: assert property (p_match2_bad)
      else $error("bad second matching byte answered");

   property p_frame_err;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_CMD && rxValid && rxFrameErr && !txValid
      |=> txValid && txData == `SBS_ERR_FRAME && state == SBS_ERRTX;
   endproperty
   a_frame_err: assert property (p_frame_err)
      else $error("framing error code wrong");

   property p_err_three;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_ERRTX && txValid && txReady ##1
      txValid && txReady ##1 txValid && txReady
      |=> !txValid ##1 state == SBS_IDLE;
   endproperty
   a_err_three: assert property (p_err_three)
      else $error("error code not sent three times then idle");

   property p_romset_reply;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_ROMSET && rxValid && !rxErr && !txValid
      |=> txData == `SBS_ROMEMU_OK && state == SBS_CMD;
   endproperty
   a_romset_reply: assert property (p_romset_reply)
      else $error("emulation set value not answered");

   property p_addr_silent;
      @(posedge clock) disable iff (!rst_n)
      $past(state) == SBS_ADDR && !$past(txValid) |-> !txValid;
   endproperty
   a_addr_silent: assert property (p_addr_silent)
      else $error("reply during address bytes");

   property p_mismatch_idle;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_PWCMP && cmpReady && !(rxValid && rxErr) &&
      cmpRx != cmpFlash |=> state == SBS_IDLE ##1 !txValid;
   endproperty
   a_mismatch_idle: assert property (p_mismatch_idle)
      else $error("mismatch did not go silent idle");

   property p_pass_sets;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_PWCMP && cmpReady && !(rxValid && rxErr) &&
      cmpRx == cmpFlash && pwIdx + 8'h01 == pwCount && !txValid
      |=> security_program_enabled_flag && txData == `SBS_SECURE_OK
      ##1 !parallelReadAllowed;
   endproperty
   a_pass_sets: assert property (p_pass_sets)
      else $error("password pass not reported");

   property p_refuse;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_CMD && rxValid && !rxErr && !txValid &&
      security_program_enabled_flag &&
      (rxData == `SBS_CMD_WRITE || rxData == `SBS_CMD_RAMLOAD)
      |=> !extStart && txData == `SBS_ERR_CMD;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("write or loader accepted while secured");

   property p_idle_stays;
      @(posedge clock) disable iff (!rst_n)
      state == SBS_IDLE && !txValid |=> state == SBS_IDLE && !txValid;
   endproperty
   a_idle_stays: assert property (p_idle_stays)
      else $error("left idle without reset");

   c_secure_pass: cover property (@(posedge clock) disable iff (!rst_n)
      txValid && txData == `SBS_SECURE_OK);
   c_err_idle: cover property (@(posedge clock) disable iff (!rst_n)
      state == SBS_ERRTX ##[1:20] state == SBS_IDLE);
   c_romset: cover property (@(posedge clock) disable iff (!rst_n)
      state == SBS_ROMSET ##1 state == SBS_CMD);

endmodule

// >>> verification/sbs_flash_model.sv
// Flash read port seen from the handler; answers after 0 or 5 waits
module sbs_flash_model #(
   parameter logic [23:0] CountLoc = 24'h008010,
   parameter logic [7:0] PwLen = 8'h03
) (
   input wire logic clock,
   input wire logic slow,
   input wire logic memReq,
   input wire logic [23:0] memAddr,
   output logic memAck,
   output logic [7:0] memData
);
   timeunit 1ns;
   timeprecision 1ps;
   int waitCount = 0;
   initial begin
      memAck = 1'b0;
      memData = 8'h00;
   end
   // Data lines toggle between answers so a stale byte is never reused
   always @(posedge clock) begin
      memAck <= 1'b0;
      memData <= ~memData;
      if (memReq && !memAck) begin
         if (waitCount >= (slow ? 5 : 0)) begin
            waitCount <= 0;
            memAck <= 1'b1;
            if (memAddr == CountLoc) begin
               memData <= PwLen;
            end else begin
               memData <= memAddr[7:0] ^ 8'h5a;
            end
         end else begin
            waitCount <= waitCount + 1;
         end
      end
   end
endmodule

// >>> verification/testbench.sv
module testbench;
   import sbs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, rxValid = 0, rxFrameErr = 0, rxOverrun = 0;
   logic txReady = 1, partBlank = 0, securityStored = 0, chipEraseDone = 0;
   logic extDone = 0, slow = 0;
   logic [7:0] rxData = 8'h00;
   logic txValid, memReq, memAck, extStart, idle;
   logic security_program_enabled_flag, parallelReadAllowed;
   logic sectorEraseAllowed;
   logic [7:0] txData, memData, extCmd;
   logic [23:0] memAddr;
   logic [7:0] txQ[$];
   int errors = 0, checks = 0, extSeen = 0;

   sbs_cmd_handler u_sbs_cmd_handler (.clock, .rst_n, .rxValid, .rxData,
      .rxFrameErr, .rxOverrun, .txReady, .txValid, .txData, .memReq,
      .memAddr, .memAck, .memData, .partBlank, .securityStored,
      .chipEraseDone, .extDone, .extStart, .extCmd, .idle,
      .security_program_enabled_flag, .parallelReadAllowed,
      .sectorEraseAllowed);
   sbs_flash_model u_sbs_flash_model (.clock, .slow, .memReq, .memAddr,
      .memAck, .memData);

   initial begin
      forever #12.5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (rst_n && txValid === 1'b1 && txReady) txQ.push_back(txData);
      if (extStart === 1'b1) extSeen++;
   end

   task report_and_stop;
      $display("checks %0d, errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #(20000 * 25);
      errors++;
      report_and_stop;
   end

   task check(input string name, input logic [23:0] seen,
              input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // The controller waits for the answer, so every byte gets a quiet gap
   task send(input logic [7:0] b, input logic fe = 0, input logic ov = 0);
      rxData = b;
      rxFrameErr = fe;
      rxOverrun = ov;
      rxValid = 1;
      step(1);
      rxValid = 0;
      rxFrameErr = 0;
      rxOverrun = 0;
      rxData = ~b;
      step(12);
   endtask

   // Expects exactly n copies of b since the last call
   task expect_tx(input string name, input logic [7:0] b, input int n);
      check({name, " count"}, txQ.size(), n);
      foreach (txQ[i]) check(name, txQ[i], b);
      txQ.delete();
   endtask

   task do_reset(input logic stored);
      rst_n = 0;
      securityStored = stored;
      step(6);
      txQ.delete();
      check("txValid in reset", txValid, 0);
      rst_n = 1;
      step(2);
      check("parallel read", parallelReadAllowed, !stored);
      check("stored flag", security_program_enabled_flag, stored);
      check("idle after reset", idle, 0);
   endtask

   task handshake(input logic [7:0] a, input logic [7:0] b);
      send(a);
      expect_tx("match1", a, 1);
      send(b);
      expect_tx("match2", b, 1);
   endtask

   task send_addr(input logic [47:0] a);
      for (int i = 5; i >= 0; i--) send(a[i*8 +: 8]);
   endtask

   task sc_match;
      txReady = 0;
      send(8'h55);
      expect_tx("bad match1", 8'h00, 0);
      send(8'h86);
      check("held valid", txValid, 1);
      check("held data", txData, 8'h86);
      txReady = 1;
      step(2);
      expect_tx("match1", 8'h86, 1);
      send(8'h12);
      expect_tx("bad match2", 8'h00, 0);
      send(8'hcf);
      expect_tx("match2", 8'hcf, 1);
   endtask

   // Every other known command, write and loader too while unsecured
   task sc_emul;
      logic [7:0] ext [6] = '{8'hf0, 8'h30, 8'h60, 8'h40, 8'hc0, 8'hc3};
      send(8'hd0);
      expect_tx("emul echo", 8'hd0, 1);
      send(8'h01);
      expect_tx("emul reply", 8'hd1, 1);
      check("emul flag", security_program_enabled_flag, 0);
      foreach (ext[i]) begin
         send(ext[i]);
         expect_tx("ext echo", ext[i], 1);
         check("ext start", extSeen, i + 1);
         check("ext cmd", extCmd, ext[i]);
         extDone = 1;
         step(1);
         extDone = 0;
         step(2);
      end
   endtask

   task sc_secure(input logic slowFlash);
      slow = slowFlash;
      send(8'hfa);
      expect_tx("secure echo", 8'hfa, 1);
      send_addr(48'h008010_008020);
      expect_tx("address silence", 8'h00, 0);
      for (int i = 0; i < 3; i++) send(8'((8'h20 + i) ^ 8'h5a));
      expect_tx("secure reply", 8'hfb, 1);
      check("flag set", security_program_enabled_flag, 1);
      check("read blocked", parallelReadAllowed, 0);
      check("erase blocked", sectorEraseAllowed, 0);
   endtask

   task sc_after_secure(input logic [7:0] cmd);
      send(8'hd0);
      expect_tx("next command", 8'hd0, 1);
      send(8'h00);
      expect_tx("next reply", 8'hd1, 1);
      send(cmd);
      expect_tx("refused command", 8'h63, 3);
      check("no ext start", extSeen, 6);
      check("idle after refusal", idle, 1);
      send(8'h86);
      expect_tx("idle ignores", 8'h00, 0);
      chipEraseDone = 1;
      step(1);
      chipEraseDone = 0;
      step(2);
      check("flag cleared", security_program_enabled_flag, 0);
   endtask

   task sc_cmd_errors;
      logic [7:0] cmds [4] = '{8'hd0, 8'hd0, 8'hd0, 8'h55};
      logic [7:0] codes [4] = '{8'ha1, 8'ha3, 8'ha1, 8'h63};
      logic [3:0] fe = 4'b0101;
      logic [3:0] ov = 4'b0110;
      for (int i = 0; i < 4; i++) begin
         do_reset(0);
         handshake(8'h30, 8'hcf);
         send(cmds[i], fe[i], ov[i]);
         expect_tx("error code", codes[i], 3);
         check("idle after error", idle, 1);
      end
   endtask

   // Mismatch, blank part, error in an address, error in the string
   task sc_silent_idle(input int kind);
      do_reset(0);
      handshake(8'h86, 8'h79);
      partBlank = (kind == 1);
      send(8'hfa);
      txQ.delete();
      if (kind == 2) send(8'h00, 1, 0);
      else send_addr(48'h008010_008020);
      if (kind == 0) send(8'h00);
      if (kind == 3) send(8'h7a, 0, 1);
      send(8'h86);
      expect_tx("silent idle", 8'h00, 0);
      check("silent idle state", idle, 1);
      check("flag unset", security_program_enabled_flag, 0);
      partBlank = 0;
   endtask

   initial begin
      do_reset(1);
      do_reset(0);
      sc_match;
      sc_emul;
      sc_secure(1);
      sc_after_secure(8'h30);
      do_reset(0);
      handshake(8'h86, 8'h79);
      sc_secure(0);
      sc_after_secure(8'h60);
      sc_cmd_errors;
      for (int k = 0; k < 4; k++) sc_silent_idle(k);
      report_and_stop;
   end
endmodule
